/* File: hw/io_channel_ctrl_regs.vh */
// Purpose: Shared constants for the I/O channel controller
// Assumes: Byte addresses on APB, 24-bit processor addresses
// Notes: Bit 0 is the least significant bit everywhere
//
// How it works
// - The low 32K bytes of the nonvolatile window hold real memory.
// - Sequencer stores into the protected low nonvolatile area are blocked.
// - Standard I/O offsets decode to fixed device ranges; gaps stay reserved.
// - Bus master transfers always use buffered mode.
// - Slot reset register: bits 0-7 eight slots, bit 31 standard I/O.
// - Slot reset bits 8 to 30 read back as zero; tests ignore them.
// - Controller-internal and I/O bus protocol errors are never logged in status.
// - Translation control word faults are logged as parity errors, never ECC.
// - Bus owner times out one full refresh interval after first refresh seen.
// - Slot interrupts are presented coded, through the interrupt vector table.
// - A load from the lock command raises a data storage interrupt.
// - Refresh field value 01 means a 60 microsecond refresh interval.
// - Reset or check stop clears slot reset register, forcing all slots reset.
`ifndef IO_CHANNEL_CTRL_REGS_VH
`define IO_CHANNEL_CTRL_REGS_VH

// APB register byte offsets
`define REG_CONFIG      12'h010
`define REG_STATUS      12'h020
`define REG_SLOT_RESET  12'h02C
`define REG_VECTOR_LO   12'h090
`define REG_VECTOR_HI   12'h094

// Field positions
`define CFG_MASTER_EN   0
`define CFG_REFRESH_LO  6
`define CFG_REFRESH_HI  7
`define ST_TIMEOUT      0
`define ST_CODE_CLR     8
`define ST_CODE_LO      4
`define ST_CODE_HI      7
`define SLOT_STDIO_BIT  31
`define SLOT_MASK       32'h800000FF

// Reset values
`define CONFIG_RESET    32'h00000040
`define SLOT_RESET_INIT 32'h00000000

// Error codes
`define ERR_NONE        4'h0
`define ERR_WPROTECT    4'h1
`define ERR_TCW_PARITY  4'h2
`define ERR_UNMAPPED    4'h3
`define ERR_LOCK        4'h4

// Processor address map
`define NV_SPACE        4'hA
`define NV_LOW_TAG      9'h140
`define NV_PROT_END     15'h0300
`define STDIO_PAGE      16'h5000
`define LOCK_ADDR       24'h600000

// Standard I/O offset ranges
`define SER1_LO   8'h30
`define SER1_HI   8'h37
`define SER2_LO   8'h38
`define SER2_HI   8'h3F
`define SDMA_LO   8'h40
`define SDMA_HI   8'h41
`define MOUSE_LO  8'h48
`define MOUSE_HI  8'h4F
`define KBD_LO    8'h50
`define KBD_HI    8'h59
`define DISK_LO   8'h62
`define DISK_HI   8'h67
`define PAR_LO    8'h78
`define PAR_HI    8'h7A
`define TDLY_LO   8'hE0
`define TDLY_HI   8'hE7

// Timing
`define CLK_PERIOD_NS   100
`define REFRESH_00_US   15
`define REFRESH_01_US   60
`define REFRESH_10_US   30
`define REFRESH_11_US   120

`endif

/* File: hw/refresh_timer.v */
// Purpose: Refresh interval tick generator
// Assumes: Field changes take effect at the next reload
// Notes: One-cycle tick per interval
`timescale 1ns/10ps
`default_nettype none
`include "io_channel_ctrl_regs.vh"
module refresh_timer
(
	// System
	input  wire        clk_sys,
	input  wire        reset,
	// Control
	input  wire [1:0]  refreshSel,
	output reg         refreshTick
);
	// Counts worked out at full width, then cut to the counter width on purpose
	localparam integer N00   = `REFRESH_00_US * 1000 / `CLK_PERIOD_NS;
	localparam integer N01   = `REFRESH_01_US * 1000 / `CLK_PERIOD_NS;
	localparam integer N10   = `REFRESH_10_US * 1000 / `CLK_PERIOD_NS;
	localparam integer N11   = `REFRESH_11_US * 1000 / `CLK_PERIOD_NS;
	localparam [11:0]  CYC00 = N00[11:0];
	localparam [11:0]  CYC01 = N01[11:0];
	localparam [11:0]  CYC10 = N10[11:0];
	localparam [11:0]  CYC11 = N11[11:0];

	reg  [11:0] count_ff;
	reg  [11:0] reload;

	always @*
	begin
		case (refreshSel)
			2'h0:    reload = CYC00;
			2'h1:    reload = CYC01;
			2'h2:    reload = CYC10;
			default: reload = CYC11;
		endcase
	end

	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			count_ff    <= 12'h000;
			refreshTick <= 1'b0;
		end
		else if (count_ff == 12'h000)
		begin
			count_ff    <= reload - 12'h001;
			refreshTick <= 1'b1;
		end
		else
		begin
			count_ff    <= count_ff - 12'h001;
			refreshTick <= 1'b0;
		end
	end
endmodule // refresh_timer
`default_nettype wire

/* File: hw/stdio_decoder.v */
// Purpose: Standard I/O offset decode
// Assumes: Offset is the low byte of the standard I/O page
// Notes: Purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "io_channel_ctrl_regs.vh"
module stdio_decoder
(
	// Offset in
	input  wire [7:0] offset,
	// Device selects
	output reg  [7:0] devSel,
	output wire       reserved
);
	always @*
	begin
		devSel    = 8'h00;
		devSel[0] = (offset >= `SER1_LO)  && (offset <= `SER1_HI);
		devSel[1] = (offset >= `SER2_LO)  && (offset <= `SER2_HI);
		devSel[2] = (offset >= `SDMA_LO)  && (offset <= `SDMA_HI);
		devSel[3] = (offset >= `MOUSE_LO) && (offset <= `MOUSE_HI);
		devSel[4] = (offset >= `KBD_LO)   && (offset <= `KBD_HI);
		devSel[5] = (offset >= `DISK_LO)  && (offset <= `DISK_HI);
		devSel[6] = (offset >= `PAR_LO)   && (offset <= `PAR_HI);
		devSel[7] = (offset >= `TDLY_LO)  && (offset <= `TDLY_HI);
	end

	assign reserved = (devSel == 8'h00);
endmodule // stdio_decoder
`default_nettype wire

/* File: hw/io_channel_ctrl.v */
// Purpose: I/O channel controller core: registers, nonvolatile window, decode
// Assumes: Processor requests are single-cycle pulses, answered next cycle
// Notes: APB slave inserts one wait state on every access
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "io_channel_ctrl_regs.vh"
module io_channel_ctrl
#(
	parameter NV_WORDS = 8192
)
(
	// System
	input  wire        clk_sys,
	input  wire        reset,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	// Processor load/store port
	input  wire        procReq,
	input  wire        procWrite,
	input  wire        procFromSeq,
	input  wire [23:0] procAddr,
	input  wire [31:0] procWdata,
	output reg         procDone,
	output reg  [31:0] procRdata,
	output reg         procDsi,
	output reg         procErr,
	// Standard I/O bus
	output reg  [7:0]  ioSel,
	output reg         ioWrite,
	output reg  [7:0]  ioOffset,
	output reg  [31:0] ioWdata,
	input  wire [31:0] ioRdata,
	// Channel events
	input  wire        busOwned,
	input  wire        tcwParityErr,
	input  wire        checkStop,
	output reg         busTimeout,
	output wire        bmBuffered,
	// Slot resets, low means held in reset
	output wire [7:0]  slotResetN,
	output wire        stdioResetN,
	// Coded interrupts
	input  wire [7:0]  slotIrq,
	output reg         intValid,
	output reg  [7:0]  intVector
);
	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_ARMED = 3'b010;
	localparam [2:0] ST_COUNT = 3'b100;
	reg  [31:0] nvMem [0:NV_WORDS-1];
	reg  [31:0] config_ff;
	reg  [31:0] slotCtrl_ff;
	reg  [31:0] vecLo_ff;
	reg  [31:0] vecHi_ff;
	reg         timeout_ff;
	reg  [3:0]  errCode_ff;
	reg         apbWait_ff;
	reg  [2:0]  tmoState_ff;
	reg  [2:0]  nxt_tmoState;
	reg         nxt_timeout;
	reg  [3:0]  nxt_errCode;
	reg  [31:0] rdMux;
	reg         rdHit;
	reg  [3:0]  procEvent;
	reg  [7:0]  nxt_vector;
	reg         nxt_intValid;
	integer     i;
	wire        refreshTick;
	wire [7:0]  devSel;
	wire        stdioRsvd;
	wire        apbAccess;
	wire        apbWr;
	wire        nvSpace;
	wire        nvLow;
	wire        nvProt;
	wire        stdioSpace;
	wire        lockHit;
	wire [63:0] vecAll;
	assign apbAccess = psel & penable;
	assign pready    = apbWait_ff;
	assign apbWr     = apbAccess & apbWait_ff & pwrite;
	assign bmBuffered = 1'b1;
	// Slot resets follow the register directly, no extra gating
	assign slotResetN  = slotCtrl_ff[7:0];
	assign stdioResetN = slotCtrl_ff[`SLOT_STDIO_BIT];
	refresh_timer u_refresh
	(
		.clk_sys     (clk_sys),
		.reset       (reset),
		.refreshSel  (config_ff[`CFG_REFRESH_HI:`CFG_REFRESH_LO]),
		.refreshTick (refreshTick)
	);
	stdio_decoder u_decode
	(
		.offset   (procAddr[7:0]),
		.devSel   (devSel),
		.reserved (stdioRsvd)
	);
	// Processor address classification
	assign nvSpace    = (procAddr[23:20] == `NV_SPACE);
	assign nvLow      = (procAddr[23:15] == `NV_LOW_TAG);
	assign nvProt     = nvLow && (procAddr[14:0] < `NV_PROT_END);
	assign stdioSpace = (procAddr[23:8] == `STDIO_PAGE);
	assign lockHit    = (procAddr == `LOCK_ADDR);
	// APB read mux; slot reset unused bits read as zero
	always @*
	begin
		rdMux = 32'h00000000;
		rdHit = 1'b1;
		case (paddr)
			`REG_CONFIG:     rdMux = config_ff;
			`REG_STATUS:
			begin
				rdMux[`ST_TIMEOUT] = timeout_ff;
				rdMux[`ST_CODE_HI:`ST_CODE_LO] = errCode_ff;
			end
			`REG_SLOT_RESET: rdMux = slotCtrl_ff & `SLOT_MASK;
			`REG_VECTOR_LO:  rdMux = vecLo_ff;
			`REG_VECTOR_HI:  rdMux = vecHi_ff;
			default:         rdHit = 1'b0;
		endcase
	end
	// APB handshake: first access cycle prepares, second completes
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			apbWait_ff <= 1'b0;
			prdata     <= 32'h00000000;
			pslverr    <= 1'b0;
		end
		else if (apbAccess && !apbWait_ff)
		begin
			apbWait_ff <= 1'b1;
			prdata     <= pwrite ? 32'h00000000 : rdMux;
			pslverr    <= ~rdHit;
		end
		else
		begin
			apbWait_ff <= 1'b0;
			pslverr    <= 1'b0;
		end
	end
	// Software registers
	always @(posedge clk_sys)
	begin
		if (reset || checkStop)
		begin
			config_ff   <= `CONFIG_RESET;
			slotCtrl_ff <= `SLOT_RESET_INIT;
		end
		else if (apbWr && rdHit)
		begin
			if (paddr == `REG_CONFIG)
				config_ff <= pwdata;
			if (paddr == `REG_SLOT_RESET)
				slotCtrl_ff <= pwdata & `SLOT_MASK;
		end
	end
	// Vector table keeps its contents across check stop
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			vecLo_ff <= 32'h00000000;
			vecHi_ff <= 32'h00000000;
		end
		else if (apbWr)
		begin
			if (paddr == `REG_VECTOR_LO)
				vecLo_ff <= pwdata;
			if (paddr == `REG_VECTOR_HI)
				vecHi_ff <= pwdata;
		end
	end
	// Bus timeout: arm on ownership, count from first refresh, fire on next
	always @*
	begin
		nxt_tmoState = tmoState_ff;
		case (tmoState_ff)
			ST_IDLE:
				if (busOwned)
					nxt_tmoState = ST_ARMED;
			ST_ARMED:
				if (!busOwned)
					nxt_tmoState = ST_IDLE;
				else if (refreshTick)
					nxt_tmoState = ST_COUNT;
			ST_COUNT:
				if (!busOwned || refreshTick)
					nxt_tmoState = ST_IDLE;
			default:
				nxt_tmoState = ST_IDLE;
		endcase
	end

	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			tmoState_ff <= ST_IDLE;
			busTimeout  <= 1'b0;
		end
		else
		begin
			tmoState_ff <= nxt_tmoState;
			busTimeout  <= (tmoState_ff == ST_COUNT) && busOwned && refreshTick;
		end
	end
	// Processor event classification for error logging
	always @*
	begin
		procEvent = `ERR_NONE;
		if (procReq)
		begin
			if (lockHit && !procWrite)
				procEvent = `ERR_LOCK;
			else if (nvProt && procWrite && procFromSeq)
				procEvent = `ERR_WPROTECT;
			else if (nvSpace && !nvLow)
				procEvent = `ERR_UNMAPPED;
			else if (stdioSpace && stdioRsvd)
				procEvent = `ERR_UNMAPPED;
			else if (!nvSpace && !stdioSpace && !lockHit)
				procEvent = `ERR_UNMAPPED;
		end
	end
	// Status: hardware set wins over software clear; protocol errors not logged
	always @*
	begin
		nxt_timeout = timeout_ff;
		nxt_errCode = errCode_ff;
		if (apbWr && paddr == `REG_STATUS)
		begin
			if (pwdata[`ST_TIMEOUT])
				nxt_timeout = 1'b0;
			if (pwdata[`ST_CODE_CLR])
				nxt_errCode = `ERR_NONE;
		end
		if (busTimeout)
			nxt_timeout = 1'b1;
		if (tcwParityErr)
			nxt_errCode = `ERR_TCW_PARITY;
		else if (procEvent != `ERR_NONE)
			nxt_errCode = procEvent;
	end

	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			timeout_ff <= 1'b0;
			errCode_ff <= `ERR_NONE;
		end
		else
		begin
			timeout_ff <= nxt_timeout;
			errCode_ff <= nxt_errCode;
		end
	end
	// Nonvolatile memory, no reset on contents
	always @(posedge clk_sys)
	begin
		if (procReq && procWrite && nvLow && !(nvProt && procFromSeq))
			nvMem[procAddr[14:2]] <= procWdata;
	end
	// Processor answers, one cycle after the request
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			procDone  <= 1'b0;
			procRdata <= 32'h00000000;
			procDsi   <= 1'b0;
			procErr   <= 1'b0;
			ioSel     <= 8'h00;
			ioWrite   <= 1'b0;
			ioOffset  <= 8'h00;
			ioWdata   <= 32'h00000000;
		end
		else
		begin
			procDone <= procReq;
			procDsi  <= (procEvent == `ERR_LOCK);
			procErr  <= (procEvent != `ERR_NONE) && (procEvent != `ERR_LOCK);
			ioSel    <= (procReq && stdioSpace) ? devSel : 8'h00;
			ioWrite  <= procReq && stdioSpace && procWrite;
			ioOffset <= procReq ? procAddr[7:0] : ioOffset;
			ioWdata  <= procReq ? procWdata : ioWdata;
			if (procReq && !procWrite && nvLow)
				procRdata <= nvMem[procAddr[14:2]];
			else if (procReq && !procWrite && stdioSpace && !stdioRsvd)
				procRdata <= ioRdata;
			else if (procReq)
				procRdata <= 32'h00000000; // Lock load returns no data
		end
	end
	// Coded interrupts: lowest active slot wins, vector from the table
	assign vecAll = {vecHi_ff, vecLo_ff};
	always @*
	begin
		nxt_vector   = intVector;
		nxt_intValid = 1'b0;
		for (i = 7; i >= 0; i = i - 1)
		begin
			if (slotIrq[i])
			begin
				nxt_vector   = vecAll[i*8 +: 8];
				nxt_intValid = 1'b1;
			end
		end
		// Presentation inhibited until software sets master enable
		if (!config_ff[`CFG_MASTER_EN])
			nxt_intValid = 1'b0;
	end

	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			intValid  <= 1'b0;
			intVector <= 8'h00;
		end
		else
		begin
			intValid  <= nxt_intValid;
			intVector <= nxt_vector;
		end
	end
endmodule // io_channel_ctrl
`default_nettype wire

/* File: verif/io_channel_ctrl_sva.sv */
// Purpose: Port checks for the I/O channel controller
// Assumes: Refresh field stays at 01 while the bus is held
// Notes: Attached by the bind at the foot
`timescale 1ns/10ps
`default_nettype none
module io_channel_ctrl_sva
(
	// System
	input wire logic        clk_sys,
	input wire logic        reset,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	// Processor port
	input wire logic        procReq,
	input wire logic        procWrite,
	input wire logic        procFromSeq,
	input wire logic [23:0] procAddr,
	input wire logic        procDone,
	input wire logic        procDsi,
	input wire logic        procErr,
	input wire logic [7:0]  ioSel,
	// Channel
	input wire logic        busOwned,
	input wire logic        busTimeout,
	input wire logic        bmBuffered,
	input wire logic        checkStop,
	input wire logic [7:0]  slotResetN,
	input wire logic        stdioResetN,
	input wire logic [7:0]  slotIrq,
	input wire logic        intValid
);
	logic [11:0] ownCnt_ff;
	logic [11:0] nxt_ownCnt;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	assign nxt_ownCnt = busOwned ? ownCnt_ff + 12'h001 : 12'h000;
	always_ff @(posedge clk_sys)
		ownCnt_ff <= reset ? 12'h000 : nxt_ownCnt;

	a_apb_one_wait: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
		else $error("APB answer not after one wait state");
	a_nv_low_ok: assert property (procReq && !procFromSeq && procAddr[23:15] == 9'h140
		|=> procDone && !procErr) else $error("low nonvolatile access refused");
	a_seq_block: assert property (procReq && procWrite && procFromSeq
		&& procAddr[23:10] == 14'h2800 && procAddr[9:8] != 2'b11 |=> procErr)
		else $error("sequencer store into protected area not refused");
	a_ser1_sel: assert property (procReq && procAddr[23:8] == 16'h5000
		&& procAddr[7:0] >= 8'h30 && procAddr[7:0] <= 8'h37 |=> ioSel == 8'h01)
		else $error("serial port one not selected");
	a_low_gap: assert property (procReq && procAddr[23:8] == 16'h5000
		&& procAddr[7:0] < 8'h30 |=> procErr && ioSel == 8'h00)
		else $error("reserved offset selected a device");
	a_buffered: assert property (bmBuffered)
		else $error("bus master mode not buffered");
	a_timeout_min: assert property (busTimeout |-> $past(ownCnt_ff) >= 12'd599)
		else $error("bus timeout before one full interval");
	a_int_cause: assert property (intValid |-> $past(slotIrq) != 8'h00)
		else $error("interrupt presented without a slot request");
	a_lock_load: assert property (procReq && !procWrite && procAddr == 24'h600000
		|=> procDone && procDsi) else $error("lock load gave no storage interrupt");
	a_chk_clear: assert property (checkStop |=> slotResetN == 8'h00 && !stdioResetN)
		else $error("check stop left a slot out of reset");
	a_rst_clear: assert property ($fell(reset) |-> slotResetN == 8'h00 && !stdioResetN)
		else $error("slots not held in reset after reset");
endmodule // io_channel_ctrl_sva

bind io_channel_ctrl io_channel_ctrl_sva chk (.clk_sys, .reset, .psel, .penable, .pready,
	.procReq, .procWrite, .procFromSeq, .procAddr, .procDone, .procDsi, .procErr, .ioSel,
	.busOwned, .busTimeout, .bmBuffered, .checkStop, .slotResetN, .stdioResetN, .slotIrq,
	.intValid);
`default_nettype wire

/* File: verif/io_bus_partner.sv */
// Purpose: Adapter and standard I/O device model
// Assumes: Bench commands each bus hold
// Notes: Read data moves on every device access
`timescale 1ns/10ps
`default_nettype none
module io_bus_partner
(
	// System
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Bench commands
	input  wire logic        holdReq,
	input  wire logic [11:0] holdLen,
	// Bus side
	input  wire logic [7:0]  ioSel,
	output var  logic        busOwned,
	output var  logic [31:0] ioRdata
);
	logic [11:0] holdCnt_ff;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			holdCnt_ff <= 12'h000;
		else if (holdReq)
			holdCnt_ff <= holdLen;
		else if (holdCnt_ff != 12'h000)
			holdCnt_ff <= holdCnt_ff - 12'h001;
	end
	assign busOwned = holdCnt_ff != 12'h000;

	// Stale captures show up as wrong data
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			ioRdata <= 32'h5A5A0001;
		else if (ioSel != 8'h00)
			ioRdata <= {ioRdata[30:0], ~ioRdata[31]};
	end
endmodule // io_bus_partner
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: Self-checking bench for io_channel_ctrl
// Assumes: Seed 42, 10 MHz clock
// Notes: Partner holds the bus on command
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk_sys, reset, psel, penable, pwrite, procReq, procWrite, procFromSeq;
	logic        tcwParityErr, checkStop, holdReq, err;
	logic [11:0] paddr, holdLen;
	logic [23:0] procAddr;
	logic [31:0] pwdata, procWdata, rd, val, ioExp;
	logic [7:0]  slotIrq, dev;
	wire  [31:0] prdata, procRdata, ioWdata, ioRdata;
	wire  [7:0]  ioSel, ioOffset, slotResetN, intVector;
	wire         pready, pslverr, procDone, procDsi, procErr, ioWrite;
	wire         busOwned, busTimeout, bmBuffered, stdioResetN, intValid;
	int          miscompares, tests_run, n, i, seed;
	int          cyc = 0;
	logic [7:0]  loTab [8] = '{8'h30, 8'h38, 8'h40, 8'h48, 8'h50, 8'h62, 8'h78, 8'hE0};
	logic [7:0]  hiTab [8] = '{8'h37, 8'h3F, 8'h41, 8'h4F, 8'h59, 8'h67, 8'h7A, 8'hE7};

	io_channel_ctrl uut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .procReq, .procWrite, .procFromSeq, .procAddr, .procWdata, .procDone,
		.procRdata, .procDsi, .procErr, .ioSel, .ioWrite, .ioOffset, .ioWdata, .ioRdata, .busOwned,
		.tcwParityErr, .checkStop, .busTimeout, .bmBuffered, .slotResetN, .stdioResetN, .slotIrq,
		.intValid, .intVector);
	io_bus_partner peer (.clk_sys, .reset, .holdReq, .holdLen, .ioSel, .busOwned, .ioRdata);

	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task summarize;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			miscompares++;
			summarize();
		end
	end

	task chk(input string what, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask

	function automatic logic [7:0] devOf(input logic [7:0] o);
		devOf = 8'h00;
		for (int k = 0; k < 8; k++)
			if (o >= loTab[k] && o <= hiTab[k])
				devOf = 8'h01 << k;
	endfunction

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task proc(input logic w, input logic s, input logic [23:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		procReq <= 1'b1;
		procWrite <= w;
		procFromSeq <= s;
		procAddr <= a;
		procWdata <= d;
		@(posedge clk_sys);
		ioExp = ioRdata;
		procReq <= 1'b0;
		#1;
	endtask

	task hold(input logic [11:0] len);
		@(posedge clk_sys);
		holdReq <= 1'b1;
		holdLen <= len;
		@(posedge clk_sys);
		holdReq <= 1'b0;
		for (n = 0; n < len + 4 && busTimeout !== 1'b1; n++)
			@(posedge clk_sys);
	endtask

	initial
	begin
		{psel, penable, pwrite, procReq, procWrite, procFromSeq, tcwParityErr} = '0;
		{checkStop, holdReq, paddr, holdLen, procAddr, pwdata, procWdata, slotIrq} = '0;
		seed = 42;
		reset = 1'b1;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
		chk("slotResetN", 0, slotResetN);
		chk("bmBuffered", 1, bmBuffered);
		apb(1'b0, 12'h010, 32'h0);
		chk("config", 32'h00000040, rd);
		for (i = 0; i < 6; i++)
		begin
			val = (i == 0) ? 32'hFFFFFFFF : $random(seed);
			apb(1'b1, 12'h02C, val);
			apb(1'b0, 12'h02C, 32'h0);
			chk("slotReg", val & 32'h800000FF, rd & 32'h800000FF);
			chk("slotResetN", val[7:0], slotResetN);
			chk("stdioResetN", val[31], stdioResetN);
		end
		apb(1'b1, 12'h0FC, 32'h0);
		chk("pslverr", 1, err);
		@(posedge clk_sys);
		checkStop <= 1'b1;
		@(posedge clk_sys);
		checkStop <= 1'b0;
		#1;
		chk("slotResetN", 0, {slotResetN, stdioResetN});
		apb(1'b0, 12'h02C, 32'h0);
		chk("slotReg", 0, rd & 32'h800000FF);
		for (i = 0; i < 256; i++)
		begin
			val = $random(seed);
			dev = devOf(i[7:0]);
			proc(val[0], 1'b0, {16'h5000, i[7:0]}, val);
			chk("ioSel", dev, ioSel);
			chk("procErr", dev == 8'h00, procErr);
			if (dev != 8'h00)
			begin
				chk("ioData", val[0] ? val : ioExp, val[0] ? ioWdata : procRdata);
				chk("ioWrite", val[0], ioWrite);
				chk("ioOffset", i[7:0], ioOffset);
			end
		end
		val = $random(seed);
		proc(1'b1, 1'b0, 24'hA07FFC, val);
		proc(1'b0, 1'b0, 24'hA07FFC, 32'h0);
		chk("nvData", val, procRdata);
		proc(1'b0, 1'b0, 24'hA08000, 32'h0);
		chk("procErr", 1, procErr);
		proc(1'b1, 1'b0, 24'hA00010, val);
		proc(1'b1, 1'b1, 24'hA00010, ~val);
		chk("procErr", 1, procErr);
		proc(1'b0, 1'b1, 24'hA00010, 32'h0);
		chk("nvData", val, procRdata);
		proc(1'b1, 1'b1, 24'hA00300, val);
		chk("procErr", 0, procErr);
		proc(1'b0, 1'b0, 24'h600000, 32'h0);
		chk("procDsi", 1, procDsi);
		proc(1'b1, 1'b0, 24'h600000, 32'h0);
		chk("procDsi", 0, {procDsi, procErr});
		apb(1'b1, 12'h020, 32'h00000100);
		@(posedge clk_sys);
		tcwParityErr <= 1'b1;
		@(posedge clk_sys);
		tcwParityErr <= 1'b0;
		apb(1'b0, 12'h020, 32'h0);
		chk("errCode", 2, rd[7:4]);
		apb(1'b1, 12'h010, 32'h00000041);
		apb(1'b1, 12'h090, 32'h44332211);
		apb(1'b1, 12'h094, 32'h88776655);
		for (i = 0; i < 8; i++)
		begin
			val = $random(seed);
			@(posedge clk_sys);
			slotIrq <= (val[7:0] << i) | (8'h01 << i);
			repeat (2) @(posedge clk_sys);
			#1;
			chk("intValid", 1, intValid);
			chk("intVector", 8'h11 * (i + 1), intVector);
		end
		slotIrq <= 8'h00;
		hold(12'd590);
		chk("earlyTimeout", 594, n);
		hold(12'd1300);
		chk("timeoutWindow", 1, n >= 598 && n <= 1203);
		apb(1'b0, 12'h020, 32'h0);
		chk("timeoutFlag", 1, rd[0]);
		summarize();
	end
endmodule // tb
`default_nettype wire
